// [core/sls_ff_filter.sv]
// position feedforward: percent gain then first order lag
`timescale 1ns/10ps
`include "sls_params.svh"
module sls_ff_filter
  import sls_pkg::*;
#(
  parameter int CYC_CLKS = 6250
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic i_en,
  input wire logic signed [15:0] i_ref,
  input wire logic [15:0] i_gain,
  input wire logic [15:0] i_tc,
  output logic signed [15:0] o_y
);
  logic signed [31:0] x_w;
  logic signed [47:0] diff_w;
  logic signed [47:0] step_w;
  logic signed [47:0] den_w;

  // the step shrinks with the constant; tc 0 makes the lag a plain copy
  // the constant counts in clocks, so it holds for any control cycle
  always_comb begin
    x_w = (32'(i_ref) * $signed({16'h0000, i_gain})) / `SLS_PCT;
    diff_w = 48'(x_w) - 48'(o_y);
    den_w = 48'(CYC_CLKS) + 48'(i_tc) * 48'(`SLS_TC_UNIT_CYC);
    step_w = (diff_w * 48'(CYC_CLKS)) / den_w;
  end

  // held at zero outside position control, so it restarts clean
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_en) begin
      o_y <= 16'sh0000; // R5
    end else if (i_tick) begin
      o_y <= 16'(48'(o_y) + step_w); // R6
    end
  end
endmodule

// [core/sls_mode_switch.sv]
// servo loop tuning selections and P/PI mode switch with wishbone regs
`timescale 1ns/10ps
`include "sls_params.svh"
module sls_mode_switch
  import sls_pkg::*;
#(
  parameter int CYCLE_DIV = `SLS_CYCLE_CLKS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic signed [15:0] i_torque_ref,
  input wire logic signed [15:0] i_speed_ref,
  input wire logic signed [31:0] i_pos_err,
  input wire logic signed [15:0] i_pos_ff,
  output logic o_p_ctrl,
  output logic o_cur_mode2,
  output logic o_speed_det2,
  output logic o_cur_gain_en,
  output logic [31:0] o_cur_gain_prod,
  output logic signed [15:0] o_ff_out,
  output logic o_cycle_tick
);
  localparam int ACC_SCALE = `SLS_NS_PER_S / (CYCLE_DIV * `SLS_CLK_NS);
  // named copy, since a bare literal cannot be bit-selected
  localparam logic [15:0] RST_LOOP = `SLS_RST_LOOP;

  logic [15:0] loop_method_select_reg;
  logic [15:0] current_gain_level_reg;
  logic [15:0] speed_loop_gain_reg;
  logic [15:0] feedforward_gain_reg;
  logic [15:0] feedforward_filter_tc_reg;
  logic [15:0] pp_switch_select_reg;
  logic [15:0] torque_switch_level_reg;
  logic [15:0] speed_switch_level_reg;
  logic [15:0] accel_switch_level_reg;
  logic [15:0] poserr_switch_level_reg;
  logic [15:0] ctl_reg;
  logic in_rst_reg;
  logic soft_rst_reg;
  logic [31:0] div_reg;
  logic signed [15:0] spd_prev_reg;
  logic [7:0] ofs_w;
  logic wr_w;
  logic [15:0] wd_w;
  logic [15:0] rd_w;
  logic load_w;
  sls_ctl_mode_t mode_w;
  sls_sw_sel_t sel_w;
  logic [31:0] abs_trq_w;
  logic [31:0] abs_spd_w;
  logic [31:0] abs_acc_w;
  logic [31:0] abs_per_w;
  logic over_w;

  // byte lanes 0 and 1 carry the 16-bit register data
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  function automatic logic [31:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 32'(-17'(v)) : 32'(v);
  endfunction

  assign ofs_w = {i_wb_adr[7:2], 2'b00};
  // writes land at the edge where the master sees ack high
  assign wr_w = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  assign wd_w = merge(rd_w, i_wb_dat, i_wb_sel);
  assign mode_w = sls_ctl_mode_t'(ctl_reg[1:0]);
  assign sel_w = sls_sw_sel_t'(pp_switch_select_reg[2:0]);
  assign load_w = in_rst_reg || soft_rst_reg;

  // read mux; unmapped offsets read zero
  always_comb begin
    case (ofs_w)
      `SLS_OFS_LOOP: rd_w = loop_method_select_reg;
      `SLS_OFS_CGL: rd_w = current_gain_level_reg;
      `SLS_OFS_SLG: rd_w = speed_loop_gain_reg;
      `SLS_OFS_FFG: rd_w = feedforward_gain_reg;
      `SLS_OFS_FFT: rd_w = feedforward_filter_tc_reg;
      `SLS_OFS_PPS: rd_w = pp_switch_select_reg;
      `SLS_OFS_TRQ: rd_w = torque_switch_level_reg;
      `SLS_OFS_SPD: rd_w = speed_switch_level_reg;
      `SLS_OFS_ACC: rd_w = accel_switch_level_reg;
      `SLS_OFS_PER: rd_w = poserr_switch_level_reg;
      `SLS_OFS_CTL: rd_w = ctl_reg;
      `SLS_OFS_STA: rd_w = {12'h000, o_cur_gain_en, o_speed_det2,
                            o_cur_mode2, o_p_ctrl};
      default: rd_w = 16'h0000;
    endcase
  end

  // single wait state: ack one cycle after the request, then dropped
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
      o_wb_dat <= {16'h0000, rd_w};
    end
  end

  // setting registers; values outside their range are dropped whole
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      loop_method_select_reg <= `SLS_RST_LOOP;
      current_gain_level_reg <= `SLS_RST_CGL; // R2
      speed_loop_gain_reg <= `SLS_RST_SLG;
      feedforward_gain_reg <= `SLS_RST_FFG;
      feedforward_filter_tc_reg <= `SLS_RST_FFT;
      pp_switch_select_reg <= `SLS_RST_PPS;
      torque_switch_level_reg <= `SLS_RST_TRQ;
      speed_switch_level_reg <= `SLS_RST_SPD;
      accel_switch_level_reg <= `SLS_RST_ACC;
      poserr_switch_level_reg <= `SLS_RST_PER;
      ctl_reg <= 16'h0000;
    end else if (wr_w) begin
      case (ofs_w)
        `SLS_OFS_LOOP: loop_method_select_reg <= wd_w;
        `SLS_OFS_CGL: begin
          if (wd_w >= `SLS_MIN_CGL && wd_w <= `SLS_MAX_CGL) begin
            current_gain_level_reg <= wd_w; // R2
          end
        end
        `SLS_OFS_SLG: speed_loop_gain_reg <= wd_w;
        `SLS_OFS_FFG: begin
          if (wd_w <= `SLS_MAX_FFG) begin
            feedforward_gain_reg <= wd_w; // R5
          end
        end
        `SLS_OFS_FFT: begin
          if (wd_w <= `SLS_MAX_FFT) begin
            feedforward_filter_tc_reg <= wd_w; // R6
          end
        end
        `SLS_OFS_PPS: begin
          if (wd_w <= `SLS_MAX_PPS) begin
            pp_switch_select_reg <= wd_w; // R7
          end
        end
        `SLS_OFS_TRQ: begin
          if (wd_w <= `SLS_MAX_TRQ) begin
            torque_switch_level_reg <= wd_w; // R10
          end
        end
        `SLS_OFS_SPD: begin
          if (wd_w <= `SLS_MAX_SPD) begin
            speed_switch_level_reg <= wd_w; // R11
          end
        end
        `SLS_OFS_ACC: begin
          if (wd_w <= `SLS_MAX_ACC) begin
            accel_switch_level_reg <= wd_w; // R12
          end
        end
        `SLS_OFS_PER: begin
          if (wd_w <= `SLS_MAX_PER) begin
            poserr_switch_level_reg <= wd_w; // R13
          end
        end
        `SLS_OFS_CTL: ctl_reg <= {13'h0000, wd_w[2:0]};
        default: ctl_reg <= ctl_reg;
      endcase
    end
  end

  // soft restart strobe; it never stores, so it always reads zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_w && ofs_w == `SLS_OFS_CTL &&
                      wd_w[`SLS_CTL_RST_BIT];
    end
  end

  // in_rst_reg marks the first cycle after release for the latch below
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      in_rst_reg <= 1'b1;
    end else begin
      in_rst_reg <= 1'b0;
    end
  end

  // working copies of restart-only digits; later writes wait
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_cur_mode2 <= RST_LOOP[`SLS_LOOP_CUR_BIT]; // R1
      o_speed_det2 <= RST_LOOP[`SLS_LOOP_SPD_BIT]; // R4
    end else if (load_w) begin
      o_cur_mode2 <= loop_method_select_reg[`SLS_LOOP_CUR_BIT]; // R17
      o_speed_det2 <= loop_method_select_reg[`SLS_LOOP_SPD_BIT]; // R17
    end
  end

  // current gain scaling follows the speed loop gain; off at 2000
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_cur_gain_en <= 1'b0;
      o_cur_gain_prod <= 32'h0000_0000;
    end else begin
      o_cur_gain_en <= current_gain_level_reg != `SLS_RST_CGL && // R2
                       mode_w != SLS_TORQUE; // R3
      o_cur_gain_prod <= 32'(speed_loop_gain_reg) *
                         32'(current_gain_level_reg);
    end
  end

  // control cycle divider: the P/PI decision and the feedforward lag move on this tick
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      div_reg <= 32'h0000_0000;
      o_cycle_tick <= 1'b0;
    end else begin
      o_cycle_tick <= div_reg == 32'(CYCLE_DIV - 1);
      if (div_reg == 32'(CYCLE_DIV - 1)) begin
        div_reg <= 32'h0000_0000;
      end else begin
        div_reg <= div_reg + 32'h0000_0001;
      end
    end
  end

  // magnitudes, so both directions of travel switch alike
  always_comb begin
    abs_trq_w = mag16(i_torque_ref);
    abs_spd_w = mag16(i_speed_ref);
    abs_acc_w = mag16(16'(i_speed_ref - spd_prev_reg)) * 32'(ACC_SCALE);
    abs_per_w = i_pos_err[31] ? 32'(-i_pos_err) : 32'(i_pos_err);
  end

  // one comparator picked by the select; strict greater-than
  always_comb begin
    case (sel_w)
      SLS_SW_TRQ: over_w = mode_w != SLS_TORQUE &&
                           abs_trq_w > 32'(torque_switch_level_reg); // R10
      SLS_SW_SPD: over_w = mode_w != SLS_TORQUE &&
                           abs_spd_w > 32'(speed_switch_level_reg); // R11
      SLS_SW_ACC: over_w = mode_w == SLS_SPEED &&
                           abs_acc_w > 32'(accel_switch_level_reg); // R14
      SLS_SW_PER: over_w = mode_w == SLS_POSITION &&
                           abs_per_w > 32'(poserr_switch_level_reg); // R15
      default: over_w = 1'b0; // R7
    endcase
  end

  // decision held between ticks; I-P control never switches
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_p_ctrl <= 1'b0;
      spd_prev_reg <= 16'sh0000;
    end else if (o_cycle_tick) begin
      o_p_ctrl <= over_w && !ctl_reg[`SLS_CTL_IP_BIT]; // R8 R9 R16
      spd_prev_reg <= i_speed_ref;
    end
  end

  // feedforward path, alive only in position control
  sls_ff_filter #(
    .CYC_CLKS(CYCLE_DIV)
  ) u_ff (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_tick(o_cycle_tick),
    .i_en(mode_w == SLS_POSITION), // R5
    .i_ref(i_pos_ff),
    .i_gain(feedforward_gain_reg),
    .i_tc(feedforward_filter_tc_reg),
    .o_y(o_ff_out)
  );

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ans;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  sequence s_trq_over;
    o_cycle_tick && sel_w == SLS_SW_TRQ && !ctl_reg[`SLS_CTL_IP_BIT] &&
      mode_w != SLS_TORQUE && abs_trq_w > 32'(torque_switch_level_reg);
  endsequence

  bus_answer_a: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  work_latch_a: assert property ( // R17
    !$past(load_w) |-> $stable(o_cur_mode2) && $stable(o_speed_det2))
    else $error("restart digit moved without restart");
  gain_torque_a: assert property ( // R3
    mode_w == SLS_TORQUE |=> !o_cur_gain_en)
    else $error("gain level active in torque mode");
  gain_default_a: assert property ( // R2
    current_gain_level_reg == `SLS_RST_CGL |=> !o_cur_gain_en)
    else $error("gain level active at default");
  ff_position_a: assert property ( // R5
    mode_w != SLS_POSITION |=> o_ff_out == 16'sh0000)
    else $error("feedforward outside position control");
  ip_disable_a: assert property ( // R9
    o_cycle_tick && ctl_reg[`SLS_CTL_IP_BIT] |=> !o_p_ctrl)
    else $error("switching under I-P control");
  sel_none_a: assert property ( // R7
    o_cycle_tick && sel_w == SLS_SW_NONE |=> !o_p_ctrl)
    else $error("switching with select none");
  trq_switch_a: assert property (s_trq_over |=> o_p_ctrl) // R10
    else $error("torque level did not give P control");
  per_only_a: assert property ( // R15
    o_cycle_tick && sel_w == SLS_SW_PER && mode_w != SLS_POSITION
      |=> !o_p_ctrl)
    else $error("position error switch outside position");
  acc_only_a: assert property ( // R12
    o_cycle_tick && sel_w == SLS_SW_ACC && mode_w != SLS_SPEED
      |=> !o_p_ctrl)
    else $error("acceleration switch outside speed");
  cycle_hold_a: assert property ( // R16
    !o_cycle_tick |=> $stable(o_p_ctrl))
    else $error("P/PI changed between control cycles");
endmodule

// [include/sls_params.svh]
// constants of the servo loop mode switch: offsets, defaults, limits
// Overview of operation
// [R1] Current control digit picks mode 1 at 0 or mode 2 at 1, default 2, used after restart.
// [R2] Current gain level accepts 100 to 2000, defaults to 2000 (off), acts at once.
// [R3] Current gain level adjustment is never active in torque control.
// [R4] Speed detection digit picks method 1 at 0 (default) or 2 at 1, used after restart.
// [R5] Feedforward acts only in position control, gain 0 to 100 percent, default 0, at once.
// [R6] Feedforward is lag filtered with a constant of 0 to 6400 x 10 us, default 0, at once.
// [R7] Switch select picks torque, speed, acceleration, position error or none, at once.
// [R8] The speed loop runs P or PI control from the select and the threshold comparison.
// [R9] With I-P speed control chosen, P/PI switching is off whatever the select says.
// [R10] Torque select gives P control when torque reference exceeds 0..800 level, default 200.
// [R11] Speed select gives P control when speed reference exceeds 0..10000 level, default 0.
// [R12] Acceleration level is 0..30000 min-1/s, default 0, used only in speed control.
// [R13] Position error level is 0..10000 reference units, default 0, used at once.
// [R14] Acceleration select gives P control when reference acceleration exceeds its level.
// [R15] Position error select gives P control above its level, in position control only.
// [R16] Comparison is strict greater-than once per control cycle; PI returns the next cycle.
// [R17] Restart-only selections load into working copies at reset release or soft restart.
`ifndef SLS_PARAMS_SVH
`define SLS_PARAMS_SVH
`define SLS_OFS_LOOP 8'h00
`define SLS_OFS_CGL 8'h04
`define SLS_OFS_SLG 8'h08
`define SLS_OFS_FFG 8'h0c
`define SLS_OFS_FFT 8'h10
`define SLS_OFS_PPS 8'h14
`define SLS_OFS_TRQ 8'h18
`define SLS_OFS_SPD 8'h1c
`define SLS_OFS_ACC 8'h20
`define SLS_OFS_PER 8'h24
`define SLS_OFS_CTL 8'h28
`define SLS_OFS_STA 8'h2c
`define SLS_LOOP_CUR_BIT 4
`define SLS_LOOP_SPD_BIT 8
`define SLS_CTL_IP_BIT 2
`define SLS_CTL_RST_BIT 3
`define SLS_RST_LOOP 16'h0010
`define SLS_RST_CGL 16'h07d0
`define SLS_RST_SLG 16'h0028
`define SLS_RST_FFG 16'h0000
`define SLS_RST_FFT 16'h0000
`define SLS_RST_PPS 16'h0000
`define SLS_RST_TRQ 16'h00c8
`define SLS_RST_SPD 16'h0000
`define SLS_RST_ACC 16'h0000
`define SLS_RST_PER 16'h0000
`define SLS_MIN_CGL 16'h0064
`define SLS_MAX_CGL 16'h07d0
`define SLS_MAX_FFG 16'h0064
`define SLS_MAX_FFT 16'h1900
`define SLS_MAX_PPS 16'h0004
`define SLS_MAX_TRQ 16'h0320
`define SLS_MAX_SPD 16'h2710
`define SLS_MAX_ACC 16'h7530
`define SLS_MAX_PER 16'h2710
`define SLS_PCT 32'sh64
`define SLS_CLK_NS 10
`define SLS_CYCLE_NS 62500
`define SLS_CYCLE_CLKS (`SLS_CYCLE_NS / `SLS_CLK_NS)
`define SLS_TC_UNIT_NS 10000
`define SLS_TC_UNIT_CYC (`SLS_TC_UNIT_NS / `SLS_CLK_NS)
`define SLS_NS_PER_S 1000000000
`endif

// [include/sls_pkg.sv]
// types shared by the servo loop mode switch
package sls_pkg;
  typedef enum logic [1:0] {
    SLS_SPEED = 2'h0,
    SLS_POSITION = 2'h1,
    SLS_TORQUE = 2'h2
  } sls_ctl_mode_t;
  typedef enum logic [2:0] {
    SLS_SW_TRQ = 3'h0,
    SLS_SW_SPD = 3'h1,
    SLS_SW_ACC = 3'h2,
    SLS_SW_PER = 3'h3,
    SLS_SW_NONE = 3'h4
  } sls_sw_sel_t;
endpackage

// [testbench/sls_loop_src.sv]
// far side model: loop references feeding the mode switch
`timescale 1ns/10ps
module sls_loop_src (
  input wire logic i_ref_clk,
  input wire logic i_tick,
  input wire logic i_ramp,
  input wire logic signed [15:0] i_trq,
  input wire logic signed [15:0] i_spd,
  input wire logic signed [31:0] i_err,
  input wire logic signed [15:0] i_ff,
  output logic signed [15:0] o_torque_ref,
  output logic signed [15:0] o_speed_ref,
  output logic signed [31:0] o_pos_err,
  output logic signed [15:0] o_pos_ff
);
  // references follow the bench; in ramp the speed steps once per tick,
  // so from the second tick on the block sees a nonzero reference acceleration
  always_ff @(posedge i_ref_clk) begin
    o_torque_ref <= i_trq;
    o_pos_err <= i_err;
    o_pos_ff <= i_ff;
    if (!i_ramp)
      o_speed_ref <= i_spd;
    else if (i_tick)
      o_speed_ref <= o_speed_ref + 16'sh1;
  end
endmodule

// [testbench/test_servo_loop_mode_switch.sv]
// self-checking bench for the servo loop mode switch
`timescale 1ns/10ps
`include "sls_params.svh"
module test_servo_loop_mode_switch
  import sls_pkg::*;
;
  logic clk;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic ramp = 1'b0;
  logic signed [15:0] trq = 16'sh0;
  logic signed [15:0] spd = 16'sh0;
  logic signed [31:0] perr = 32'sh0;
  logic signed [15:0] ff = 16'sh0;
  logic signed [15:0] trq_w, spd_w, ff_w, ff_out;
  logic signed [31:0] perr_w;
  logic [31:0] rdat, prod, q;
  logic ack, p_ctrl, mode2, det2, gen, tick;
  int err_total = 0;
  int tests_run = 0;
  int tn;

  // short control cycle keeps the run brief
  sls_mode_switch #(.CYCLE_DIV(20)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_torque_ref(trq_w), .i_speed_ref(spd_w), .i_pos_err(perr_w),
    .i_pos_ff(ff_w), .o_p_ctrl(p_ctrl), .o_cur_mode2(mode2),
    .o_speed_det2(det2), .o_cur_gain_en(gen), .o_cur_gain_prod(prod),
    .o_ff_out(ff_out), .o_cycle_tick(tick));

  // far side references
  sls_loop_src src (.i_ref_clk(clk), .i_tick(tick), .i_ramp(ramp),
    .i_trq(trq), .i_spd(spd), .i_err(perr), .i_ff(ff),
    .o_torque_ref(trq_w), .o_speed_ref(spd_w), .o_pos_err(perr_w),
    .o_pos_ff(ff_w));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // classic wishbone cycle; ack is read before this edge's updates land
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(1'b0, 1'b1);
      end_of_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(q, {16'h0000, e});
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // wait for k control ticks; decisions land at the edge after each tick
  task automatic ticks(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1 && n < 100);
      if (n >= 100) begin
        chk(1'b0, 1'b1);
        end_of_test();
      end
    end
    #1;
  endtask

  // one switching case: mode, select, level, references, expected P
  task automatic sw(input logic [3:0] c, input logic [2:0] s_sel,
                    input logic [7:0] la, input logic [15:0] lv, t, s,
                    input logic [15:0] e, input logic r, x);
    wb(1'b1, 8'h28, {12'h000, c});
    wb(1'b1, 8'h14, {13'h0000, s_sel});
    wb(1'b1, la, lv);
    @(posedge clk);
    trq <= t;
    spd <= s;
    perr <= {{16{e[15]}}, e};
    ramp <= r;
    // first tick may see old references, the next an old acceleration
    ticks(3);
    chk(p_ctrl, x);
  endtask

  logic [15:0] dflt [11] = '{16'h10, 16'h7d0, 16'h28, 16'h0, 16'h0,
    16'h0, 16'hc8, 16'h0, 16'h0, 16'h0, 16'h0};

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    idle(1);
    for (int i = 0; i < 11; i++)
      rdc(8'(i * 4), dflt[i]);
    rdc(8'h2c, 16'h2);
    rdc(8'h30, 16'h0);
    chk(mode2, 1'b1);
    chk(det2, 1'b0);
    // one decision per control cycle of 20 clocks
    ticks(1);
    tn = 0;
    do begin
      @(posedge clk);
      tn++;
    end while (tick !== 1'b1 && tn < 100);
    chk(tn, 32'd20);
    chk(gen, 1'b0);
    // gain level range and enable
    wb(1'b1, 8'h04, 16'h5dc);
    idle(3);
    chk(gen, 1'b1);
    chk(prod, 32'hea60);
    wb(1'b1, 8'h04, 16'h63);
    wb(1'b1, 8'h04, 16'h7d1);
    rdc(8'h04, 16'h5dc);
    wb(1'b1, 8'h28, 16'h2);
    idle(3);
    chk(gen, 1'b0);
    wb(1'b1, 8'h28, 16'h0);
    wb(1'b1, 8'h04, 16'h7d0);
    idle(3);
    chk(gen, 1'b0);
    // restart-only digits stay pending until a restart
    wb(1'b1, 8'h00, 16'h100);
    idle(3);
    chk(mode2, 1'b1);
    chk(det2, 1'b0);
    wb(1'b1, 8'h28, 16'h8);
    idle(4);
    chk(mode2, 1'b0);
    chk(det2, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    idle(1);
    chk(mode2, 1'b1);
    rdc(8'h00, 16'h10);
    // out-of-range levels are dropped whole
    wb(1'b1, 8'h18, 16'h321);
    rdc(8'h18, 16'hc8);
    wb(1'b1, 8'h14, 16'h5);
    rdc(8'h14, 16'h0);
    wb(1'b1, 8'h20, 16'h7531);
    rdc(8'h20, 16'h0);
    wb(1'b1, 8'h24, 16'h2711);
    rdc(8'h24, 16'h0);
    // switching cases
    sw(4'h0, 3'h0, 8'h18, 16'hc8, 16'hc9, 16'h0, 16'h0, 1'b0, 1'b1);
    sw(4'h0, 3'h0, 8'h18, 16'hc8, 16'hc8, 16'h0, 16'h0, 1'b0, 1'b0);
    sw(4'h0, 3'h0, 8'h18, 16'hc8, 16'hff37, 16'h0, 16'h0, 1'b0, 1'b1);
    sw(4'h0, 3'h1, 8'h1c, 16'h64, 16'h0, 16'h65, 16'h0, 1'b0, 1'b1);
    sw(4'h0, 3'h1, 8'h1c, 16'h64, 16'h0, 16'h64, 16'h0, 1'b0, 1'b0);
    sw(4'h0, 3'h2, 8'h20, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0);
    sw(4'h0, 3'h2, 8'h20, 16'h7530, 16'h0, 16'h0, 16'h0, 1'b1, 1'b1);
    sw(4'h1, 3'h2, 8'h20, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1, 1'b0);
    sw(4'h1, 3'h3, 8'h24, 16'h3e8, 16'h0, 16'h0, 16'h3e9, 1'b0, 1'b1);
    sw(4'h1, 3'h3, 8'h24, 16'h3e8, 16'h0, 16'h0, 16'h3e8, 1'b0, 1'b0);
    sw(4'h0, 3'h3, 8'h24, 16'h3e8, 16'h0, 16'h0, 16'h3e9, 1'b0, 1'b0);
    sw(4'h0, 3'h4, 8'h18, 16'hc8, 16'h384, 16'h0, 16'h0, 1'b0, 1'b0);
    sw(4'h4, 3'h0, 8'h18, 16'hc8, 16'h384, 16'h0, 16'h0, 1'b0, 1'b0);
    sw(4'h2, 3'h0, 8'h18, 16'hc8, 16'h384, 16'h0, 16'h0, 1'b0, 1'b0);
    // feedforward gain and lag in position control
    wb(1'b1, 8'h28, 16'h1);
    wb(1'b1, 8'h0c, 16'h32);
    @(posedge clk);
    ff <= 16'sd1000;
    ticks(2);
    chk(ff_out, 16'h1f4);
    // one tc unit is 1000 clocks, so a 20 clock tick moves about 2 percent
    wb(1'b1, 8'h10, 16'h1);
    @(posedge clk);
    ff <= 16'sd2000;
    ticks(2);
    chk(ff_out > 16'sd500 && ff_out < 16'sd540, 1'b1);
    wb(1'b1, 8'h0c, 16'h65);
    rdc(8'h0c, 16'h32);
    wb(1'b1, 8'h10, 16'h1901);
    rdc(8'h10, 16'h1);
    wb(1'b1, 8'h28, 16'h0);
    idle(3);
    chk(ff_out, 16'h0);
    end_of_test();
  end
endmodule
